// ===== hdl/mcc_defs.svh
// offsets, field positions, reset values and timing counts of the converter config block
`ifndef MCC_DEFS_SVH
`define MCC_DEFS_SVH

`define MCC_ADDR_W          8
`define MCC_DATA_W          16
`define MCC_REG_CONV_CFG    8'ha6
`define MCC_REG_SAMPLE      8'hcd
`define MCC_REG_CHAN_EN     8'h4a
`define MCC_REG_MODE        8'h4c
`define MCC_REG_STATUS      8'h4e

`define MCC_CFG_ARM_BIT     7
`define MCC_CFG_RATE_MSB    6
`define MCC_CFG_RATE_LSB    4
`define MCC_CFG_SRC_MSB     3
`define MCC_CFG_SRC_LSB     0
`define MCC_CFG_RESET       8'h00
`define MCC_CHAN_EN_RESET   2'h3
`define MCC_MODE_WB_BIT     0
`define MCC_MODE_RESET      1'h0
`define MCC_RATE_MAX_CODE   3'h4

`define MCC_CLK_MHZ         25
`define MCC_NB_RATE_HZ      8000
`define MCC_NB_PERIOD_CYC   ((`MCC_CLK_MHZ * 1000000) / `MCC_NB_RATE_HZ)
`define MCC_IRQ_NB_NS       54000
`define MCC_IRQ_WB_NS       26000
`define MCC_IRQ_NB_CYC      ((`MCC_IRQ_NB_NS * `MCC_CLK_MHZ) / 1000)
`define MCC_IRQ_WB_CYC      ((`MCC_IRQ_WB_NS * `MCC_CLK_MHZ) / 1000)
`define MCC_IRQ_CNT_W       11

`endif

// ===== hdl/mcc_pkg.sv
// types shared by the converter config block
package mcc_pkg;

  typedef enum logic [3:0] {
    MCC_SRC_AC_TIP_RING = 4'h0,
    MCC_SRC_SWITCHER_Y  = 4'h1,
    MCC_SRC_SWITCHER_Z  = 4'h2,
    MCC_SRC_TIP_V       = 4'h4,
    MCC_SRC_RING_V      = 4'h5,
    MCC_SRC_DC_TIP_RING = 4'h6,
    MCC_SRC_METAL_I     = 4'h7,
    MCC_SRC_LONG_I      = 4'h8,
    MCC_SRC_CAL_REF_I   = 4'h9,
    MCC_SRC_LOOPBACK    = 4'ha,
    MCC_SRC_NO_CONNECT  = 4'hb
  } mcc_source_type;

  typedef enum logic {
    MCC_IRQ_IDLE = 1'b0,
    MCC_IRQ_HOLD = 1'b1
  } mcc_irq_state_type;

  function automatic logic mcc_src_assigned(input logic [3:0] code);
    return (code != 4'h3) && (code <= 4'hb);
  endfunction

  // sources read back inverted, so negative line voltage gives a positive word
  function automatic logic mcc_src_inverted(input logic [3:0] code);
    return (code == MCC_SRC_SWITCHER_Y) || (code == MCC_SRC_SWITCHER_Z) ||
           (code == MCC_SRC_TIP_V) || (code == MCC_SRC_RING_V);
  endfunction

  // sources whose word weight is the coarse voltage step rather than the fine one
  function automatic logic mcc_src_coarse_v(input logic [3:0] code);
    return mcc_src_inverted(code) || (code == MCC_SRC_DC_TIP_RING);
  endfunction

endpackage

// ===== hdl/mcc_rate_gen.sv
// posting-rate divider: one tick per programmed sample period
`include "mcc_defs.svh"
module mcc_rate_gen #(
  parameter int NB_PERIOD = `MCC_NB_PERIOD_CYC
) (
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic       restart,
  input  wire logic [2:0] rate,
  input  wire logic       wideband,
  output logic            tick
);
  localparam int CW = 24;

  if (NB_PERIOD < 4 || (NB_PERIOD * 16) >= (1 << CW)) begin : g_bad_period
    $error("mcc_rate_gen: NB_PERIOD out of range");
  end

  logic [CW-1:0] cnt;
  logic [CW-1:0] next_cnt;
  logic          next_tick;
  logic [CW-1:0] period;

  always_comb begin
    period    = CW'(NB_PERIOD) << rate;
    if (wideband) begin
      period  = period >> 1;
    end
    next_cnt  = cnt + CW'(1);
    next_tick = 1'b0;
    if (restart || rate > `MCC_RATE_MAX_CODE) begin
      next_cnt = '0;
    end else if (cnt >= period - CW'(1)) begin
      next_cnt  = '0;
      next_tick = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      cnt  <= '0;
      tick <= 1'b0;
    end else begin
      cnt  <= next_cnt;
      tick <= next_tick;
    end
  end
endmodule

// ===== hdl/mcc_sample_cond.sv
// per-channel sample capture: sign conditioning and fresh flag
`include "mcc_defs.svh"
module mcc_sample_cond (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        clear,
  input  wire logic [3:0]  src,
  input  wire logic [15:0] adc_data,
  input  wire logic        adc_valid,
  input  wire logic        take,
  output logic [15:0]      held,
  output logic             fresh
);
  logic [15:0] next_held;
  logic        next_fresh;

  always_comb begin
    next_held  = held;
    next_fresh = fresh;
    if (take) begin
      next_fresh = 1'b0;
    end
    if (adc_valid) begin
      next_fresh = 1'b1;
      next_held  = adc_data;
      if (mcc_pkg::mcc_src_inverted(src)) begin
        next_held = (adc_data == 16'h8000) ? 16'h7fff : 16'(-adc_data);
      end
    end
    if (clear) begin
      next_fresh = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      held  <= 16'h0000;
      fresh <= 1'b0;
    end else begin
      held  <= next_held;
      fresh <= next_fresh;
    end
  end

  chk_sign_invert: assert property (@(posedge clk) disable iff (!resetn)
    adc_valid && !clear && mcc_pkg::mcc_src_inverted(src) && adc_data != 16'h8000
      |=> held == 16'(-$past(adc_data)))
    else $error("inverted source sample not negated");
endmodule

// ===== hdl/mcc_top.sv
// converter configuration, sample posting and data-ready interrupt
//
// Function
// - arm bit enables data-ready interrupt, default off
// - armed: interrupt on each new sample
// - interrupt self-clears after 54/26 us, or read
// - interrupt only when both channels sampled
// - 3-bit rate field, wideband doubles rate
// - post samples to highway and register together
// - 4-bit source field; reserved codes unused
// - source code to analog input mapping
// - word weight depends on selected source
// - state change overwrites source field
// - loopback source routes DAC back to ADC
// - negative battery/tip/ring voltage reads positive
// - reset clears whole config byte
// - sample word is signed 1.15 value
// - config write starts new measurement
`include "mcc_defs.svh"
module mcc_top #(
  parameter int NB_PERIOD = `MCC_NB_PERIOD_CYC
) (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [15:0]      reg_rdata,
  input  wire logic [15:0] adc_data_a,
  input  wire logic [15:0] adc_data_b,
  input  wire logic [1:0]  adc_valid,
  input  wire logic [1:0]  sys_state_change,
  output logic [3:0]       src_sel_a,
  output logic [3:0]       src_sel_b,
  output logic [1:0]       loopback_en,
  output logic [1:0]       meas_restart,
  output logic [15:0]      pcm_data,
  output logic             pcm_valid,
  output logic             irq
);
  default clocking dc @(posedge clk); endclocking
  default disable iff (!resetn);

  if (NB_PERIOD < 4) begin : g_bad_period
    $error("mcc_top: NB_PERIOD too small");
  end

  localparam logic [`MCC_IRQ_CNT_W-1:0] IRQ_NB = `MCC_IRQ_CNT_W'(`MCC_IRQ_NB_CYC);
  localparam logic [`MCC_IRQ_CNT_W-1:0] IRQ_WB = `MCC_IRQ_CNT_W'(`MCC_IRQ_WB_CYC);

  // register state
  logic [7:0]  cfg [2];
  logic [7:0]  next_cfg [2];
  logic [1:0]  chan_en;
  logic [1:0]  next_chan_en;
  logic        wideband;
  logic        next_wideband;
  logic [15:0] sample_word [2];
  logic [15:0] next_sample_word [2];
  logic [15:0] next_rdata;
  logic [3:0]  next_src_a;
  logic [3:0]  next_src_b;
  logic [1:0]  next_loopback;
  logic [1:0]  next_restart;
  logic [15:0] next_pcm_data;
  logic        next_pcm_valid;

  logic        wr_cfg;
  logic        rd_sample;
  logic        rd_sel_b;
  logic        post;
  logic        rate_tick;
  logic [15:0] held [2];
  logic [1:0]  fresh;
  logic [15:0] adc_data [2];
  logic [1:0]  scale_coarse;

  assign adc_data[0] = adc_data_a;
  assign adc_data[1] = adc_data_b;
  assign wr_cfg      = reg_wr && reg_addr == `MCC_REG_CONV_CFG;
  assign rd_sample   = reg_rd && reg_addr == `MCC_REG_SAMPLE;
  // only channel b alone selects b; both or none fall back to channel a
  assign rd_sel_b    = chan_en == 2'h2;
  assign post        = rate_tick && (&fresh);

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_chan
      mcc_sample_cond u_cond (
        .clk       (clk),
        .resetn    (resetn),
        .clear     (meas_restart[ch]),
        .src       (cfg[ch][`MCC_CFG_SRC_MSB:`MCC_CFG_SRC_LSB]),
        .adc_data  (adc_data[ch]),
        .adc_valid (adc_valid[ch]),
        .take      (post),
        .held      (held[ch]),
        .fresh     (fresh[ch])
      );
      assign scale_coarse[ch] =
        mcc_pkg::mcc_src_coarse_v(cfg[ch][`MCC_CFG_SRC_MSB:`MCC_CFG_SRC_LSB]);
    end
  endgenerate

  // posting timebase follows channel a's rate field
  mcc_rate_gen #(
    .NB_PERIOD (NB_PERIOD)
  ) u_rate (
    .clk      (clk),
    .resetn   (resetn),
    .restart  (|meas_restart),
    .rate     (cfg[0][`MCC_CFG_RATE_MSB:`MCC_CFG_RATE_LSB]),
    .wideband (wideband),
    .tick     (rate_tick)
  );

  // configuration, channel enable and mode registers
  always_comb begin
    next_chan_en  = chan_en;
    next_wideband = wideband;
    next_restart  = 2'h0;
    if (reg_wr && reg_addr == `MCC_REG_CHAN_EN) begin
      next_chan_en = reg_wdata[1:0];
    end
    if (reg_wr && reg_addr == `MCC_REG_MODE) begin
      next_wideband = reg_wdata[`MCC_MODE_WB_BIT];
    end
    for (int i = 0; i < 2; i++) begin
      next_cfg[i] = cfg[i];
      if (wr_cfg && chan_en[i]) begin
        next_cfg[i]     = reg_wdata[7:0];
        next_restart[i] = 1'b1;
        if (!mcc_pkg::mcc_src_assigned(reg_wdata[`MCC_CFG_SRC_MSB:`MCC_CFG_SRC_LSB])) begin
          next_cfg[i][`MCC_CFG_SRC_MSB:`MCC_CFG_SRC_LSB] =
            cfg[i][`MCC_CFG_SRC_MSB:`MCC_CFG_SRC_LSB];
        end
      end
      if (sys_state_change[i]) begin
        next_cfg[i][`MCC_CFG_SRC_MSB:`MCC_CFG_SRC_LSB] = mcc_pkg::MCC_SRC_AC_TIP_RING;
      end
    end
    next_src_a    = next_cfg[0][`MCC_CFG_SRC_MSB:`MCC_CFG_SRC_LSB];
    next_src_b    = next_cfg[1][`MCC_CFG_SRC_MSB:`MCC_CFG_SRC_LSB];
    next_loopback[0] = next_src_a == mcc_pkg::MCC_SRC_LOOPBACK;
    next_loopback[1] = next_src_b == mcc_pkg::MCC_SRC_LOOPBACK;
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      cfg[0]       <= `MCC_CFG_RESET;
      cfg[1]       <= `MCC_CFG_RESET;
      chan_en      <= `MCC_CHAN_EN_RESET;
      wideband     <= `MCC_MODE_RESET;
      src_sel_a    <= 4'h0;
      src_sel_b    <= 4'h0;
      loopback_en  <= 2'h0;
      meas_restart <= 2'h0;
    end else begin
      cfg[0]       <= next_cfg[0];
      cfg[1]       <= next_cfg[1];
      chan_en      <= next_chan_en;
      wideband     <= next_wideband;
      src_sel_a    <= next_src_a;
      src_sel_b    <= next_src_b;
      loopback_en  <= next_loopback;
      meas_restart <= next_restart;
    end
  end

  // sample posting to the register and the highway
  always_comb begin
    next_pcm_valid = post;
    next_pcm_data  = pcm_data;
    for (int i = 0; i < 2; i++) begin
      next_sample_word[i] = post ? held[i] : sample_word[i];
    end
    if (post) begin
      next_pcm_data = rd_sel_b ? held[1] : held[0];
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      sample_word[0] <= 16'h0000;
      sample_word[1] <= 16'h0000;
      pcm_data       <= 16'h0000;
      pcm_valid      <= 1'b0;
    end else begin
      sample_word[0] <= next_sample_word[0];
      sample_word[1] <= next_sample_word[1];
      pcm_data       <= next_pcm_data;
      pcm_valid      <= next_pcm_valid;
    end
  end

  // data-ready interrupt with automatic clear
  mcc_pkg::mcc_irq_state_type irq_state;
  mcc_pkg::mcc_irq_state_type next_irq_state;
  logic [`MCC_IRQ_CNT_W-1:0]  irq_cnt;
  logic [`MCC_IRQ_CNT_W-1:0]  next_irq_cnt;
  logic                       next_irq;
  logic                       armed;

  assign armed = cfg[0][`MCC_CFG_ARM_BIT] | cfg[1][`MCC_CFG_ARM_BIT];

  always_comb begin
    next_irq_state = irq_state;
    next_irq_cnt   = irq_cnt;
    case (irq_state)
      mcc_pkg::MCC_IRQ_IDLE: begin
        next_irq_cnt = '0;
      end
      mcc_pkg::MCC_IRQ_HOLD: begin
        next_irq_cnt = irq_cnt + `MCC_IRQ_CNT_W'(1);
        if (rd_sample || next_irq_cnt >= (wideband ? IRQ_WB : IRQ_NB)) begin
          next_irq_state = mcc_pkg::MCC_IRQ_IDLE;
          next_irq_cnt   = '0;
        end
      end
      default: begin
        next_irq_state = mcc_pkg::MCC_IRQ_IDLE;
        next_irq_cnt   = '0;
      end
    endcase
    // a new post wins over a read or timeout in the same cycle
    if (post && armed) begin
      next_irq_state = mcc_pkg::MCC_IRQ_HOLD;
      next_irq_cnt   = '0;
    end
    next_irq = next_irq_state == mcc_pkg::MCC_IRQ_HOLD;
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      irq_state <= mcc_pkg::MCC_IRQ_IDLE;
      irq_cnt   <= '0;
      irq       <= 1'b0;
    end else begin
      irq_state <= next_irq_state;
      irq_cnt   <= next_irq_cnt;
      irq       <= next_irq;
    end
  end

  // register read port, answer one cycle after the strobe
  always_comb begin
    next_rdata = 16'h0000;
    if (reg_rd) begin
      case (reg_addr)
        `MCC_REG_CONV_CFG: next_rdata = {8'h00, rd_sel_b ? cfg[1] : cfg[0]};
        `MCC_REG_SAMPLE:   next_rdata = rd_sel_b ? sample_word[1] : sample_word[0];
        `MCC_REG_CHAN_EN:  next_rdata = {14'h0000, chan_en};
        `MCC_REG_MODE:     next_rdata = {15'h0000, wideband};
        `MCC_REG_STATUS:   next_rdata = {11'h000, scale_coarse, irq, fresh};
        default:           next_rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      reg_rdata <= 16'h0000;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

  // helper: length of the current interrupt pulse, restarted by an armed post
  logic [`MCC_IRQ_CNT_W:0] irq_len;
  always_ff @(posedge clk) begin
    if (!resetn || !irq || (post && armed)) begin
      irq_len <= '0;
    end else if (!(&irq_len)) begin
      irq_len <= irq_len + (`MCC_IRQ_CNT_W + 1)'(1);
    end
  end

  chk_reset_cfg_zero: assert property (@(posedge clk) disable iff (1'b0)
    !resetn |=> cfg[0] == 8'h00 && cfg[1] == 8'h00 && !irq)
    else $error("config not cleared by reset");
  chk_irq_needs_arm: assert property ($rose(irq) |-> $past(post) && $past(armed))
    else $error("interrupt raised while disarmed");
  chk_irq_on_post: assert property (post && armed |=> irq)
    else $error("armed post did not raise interrupt");
  chk_irq_auto_clear: assert property (irq_len <= (`MCC_IRQ_CNT_W + 1)'(`MCC_IRQ_NB_CYC) + 2)
    else $error("interrupt held past its narrowband limit");
  chk_irq_read_clear: assert property (irq_state == mcc_pkg::MCC_IRQ_HOLD && rd_sample && !post
    |=> !irq)
    else $error("sample read did not clear interrupt");
  chk_post_both_fresh: assert property (rate_tick && fresh != 2'h3 |=> !pcm_valid)
    else $error("post with a stale channel");
  chk_pcm_with_reg: assert property (post |=> pcm_valid && sample_word[0] == $past(held[0]))
    else $error("highway and register not posted together");
  chk_state_src_reset: assert property (sys_state_change[0] |=> src_sel_a == 4'h0)
    else $error("state change did not overwrite source");
  chk_write_restarts: assert property (wr_cfg && chan_en[0] |=> meas_restart[0] ##2 !pcm_valid)
    else $error("config write did not restart measurement");
  chk_loopback_route: assert property (src_sel_a == 4'ha |-> loopback_en[0])
    else $error("loopback source not routed");
endmodule

// ===== bench/mcc_host_model.sv
// host bus master model for the register port
module mcc_host_model #(
  parameter int SETTLE_CYC = 8
) (
  input  wire logic   clk,
  output logic [7:0]  reg_addr,
  output logic [15:0] reg_wdata,
  output logic        reg_wr,
  output logic        reg_rd
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    reg_addr  = 8'h00;
    reg_wdata = 16'h0000;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
  end

  // released lines show the inverse so a stale value is never mistaken for a live one
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
    reg_addr  <= ~a;
    reg_wdata <= ~d;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    reg_addr <= ~a;
  endtask

  // host lets line state and converter settle before trusting words, scaled down
  task automatic settle();
    repeat (SETTLE_CYC) @(posedge clk);
  endtask
endmodule

// ===== bench/mcc_top_tb.sv
// self-checking bench for the converter configuration block
`include "mcc_defs.svh"
module mcc_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int NBP   = 16;
  localparam int LIMIT = 40000;
  logic        clk = 1'b0;
  logic        resetn = 1'b0;
  logic [7:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata, adc_data_a, adc_data_b, pcm_data, pcm_exp, wa;
  logic        reg_wr, reg_rd, pcm_valid, irq, adc_en, rd_q;
  logic [1:0]  adc_valid, one_shot, sys_state_change, loopback_en, meas_restart;
  logic [3:0]  src_sel_a, src_sel_b;
  int          n_mismatch = 0;
  int          n_checks = 0;
  int          cyc = 0;
  int          n_posts = 0;
  int          t_post, t0, n0, n, e;
  string       qn[$];
  logic [15:0] qv[$];

  always #20 clk = ~clk;

  mcc_host_model u_mcc_host_model (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd));
  mcc_top #(.NB_PERIOD(NBP)) u_mcc_top (.clk(clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .adc_data_a(adc_data_a),
    .adc_data_b(adc_data_b), .adc_valid(adc_valid), .sys_state_change(sys_state_change),
    .src_sel_a(src_sel_a), .src_sel_b(src_sel_b), .loopback_en(loopback_en), .meas_restart(meas_restart),
    .pcm_data(pcm_data), .pcm_valid(pcm_valid), .irq(irq));

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] ex, input logic [15:0] s);
    n_checks++;
    if (s !== ex) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", nm, ex, s);
    end
  endtask

  // expected word: battery, tip and ring read negated, most negative clipped
  function automatic logic [15:0] cond(input logic [15:0] w, input logic [3:0] s);
    if (s inside {4'h1, 4'h2, 4'h4, 4'h5}) return (w == 16'h8000) ? 16'h7fff : -w;
    return w;
  endfunction

  task automatic step(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    u_mcc_host_model.wr(a, d);
    #1;
  endtask

  task automatic rd_exp(input logic [7:0] a, input logic [15:0] ex, input string nm);
    qn.push_back(nm);
    qv.push_back(ex);
    u_mcc_host_model.rd(a);
  endtask

  task automatic pulse(input logic [1:0] m);
    @(posedge clk);
    one_shot <= m;
    @(posedge clk);
    one_shot <= 2'b00;
  endtask

  task automatic wait_post();
    n0 = n_posts;
    for (int i = 0; i < 700 && n_posts == n0; i++) step(1);
    chk("post_seen", 16'h0001, 16'(n_posts != n0));
  endtask

  // monitor: noted read results, highway words, converter strobes
  always @(posedge clk) begin
    cyc++;
    adc_valid <= one_shot | ((adc_en && cyc % 4 == 0) ? 2'b11 : 2'b00);
    if (rd_q) chk(qn.pop_front(), qv.pop_front(), reg_rdata);
    rd_q <= reg_rd;
    if (pcm_valid) begin
      n_posts++;
      t_post = cyc;
      chk("pcm_data", pcm_exp, pcm_data);
    end
    if (cyc == LIMIT) begin
      n_mismatch++;
      complete_run();
    end
  end

  initial begin
    void'($urandom(83));
    adc_en = 1'b0;
    one_shot = 2'b00;
    adc_valid = 2'b00;
    rd_q = 1'b0;
    sys_state_change = 2'b00;
    adc_data_a = 16'h8000;
    adc_data_b = 16'($urandom);
    pcm_exp = cond(16'h8000, 4'h4);
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    step(1);
    chk("src_sel_a", 16'h0000, {12'h000, src_sel_a});
    rd_exp(`MCC_REG_CONV_CFG, 16'h0000, "cfg_reset");
    rd_exp(8'h00, 16'h0000, "unmapped");
    wr(`MCC_REG_CONV_CFG, 16'h0084);
    chk("meas_restart", 16'h0003, {14'h0000, meas_restart});
    chk("src_sel_b", 16'h0004, {12'h000, src_sel_b});
    u_mcc_host_model.settle();
    pulse(2'b11);
    wait_post();
    chk("irq_rise", 16'h0001, {15'h0000, irq});
    rd_exp(`MCC_REG_SAMPLE, 16'h7fff, "sample_word");
    step(2);
    chk("irq_read_clear", 16'h0000, {15'h0000, irq});
    n0 = n_posts;
    pulse(2'b01);
    step(3 * NBP + 4);
    chk("single_channel_posts", 16'(n0), 16'(n_posts));
    for (int wb = 0; wb < 2; wb++) begin
      wr(`MCC_REG_MODE, 16'(wb));
      wr(`MCC_REG_CONV_CFG, 16'h0080);
      wa = 16'($urandom);
      adc_data_a <= wa;
      pcm_exp = wa;
      pulse(2'b11);
      wait_post();
      e = wb ? `MCC_IRQ_WB_CYC : `MCC_IRQ_NB_CYC;
      n = 0;
      while (irq === 1'b1 && n < 2000) begin
        step(1);
        n++;
      end
      chk("irq_hold", 16'(e), (n >= e - 1 && n <= e + 1) ? 16'(e) : 16'(n));
    end
    wr(`MCC_REG_MODE, 16'h0000);
    wr(`MCC_REG_CONV_CFG, 16'h0000);
    pulse(2'b11);
    wait_post();
    step(3);
    chk("irq_disarmed", 16'h0000, {15'h0000, irq});
    adc_en = 1'b1;
    for (int wb = 0; wb < 2; wb++) begin
      wr(`MCC_REG_MODE, 16'(wb));
      for (int r = 0; r < 8; r++) begin
        wr(`MCC_REG_CONV_CFG, 16'(r << 4));
        if (r > 4) begin
          n0 = n_posts;
          step(300);
          chk("reserved_rate_posts", 16'(n0), 16'(n_posts));
        end else begin
          wait_post();
          t0 = t_post;
          wait_post();
          chk("post_period", 16'((NBP << r) >> wb), 16'(t_post - t0));
        end
      end
    end
    adc_en = 1'b0;
    wr(`MCC_REG_MODE, 16'h0000);
    // host takes the converter offset on the no-connection source before measuring
    wr(`MCC_REG_CONV_CFG, 16'h000b);
    wa = 16'($urandom);
    adc_data_a <= wa;
    pcm_exp = wa;
    pulse(2'b11);
    wait_post();
    rd_exp(`MCC_REG_SAMPLE, wa, "offset_word");
    wr(`MCC_REG_CONV_CFG, 16'h0005);
    wa = 16'($urandom);
    adc_data_a <= wa;
    pcm_exp = cond(wa, 4'h5);
    pulse(2'b11);
    wait_post();
    rd_exp(`MCC_REG_SAMPLE, cond(wa, 4'h5), "ring_word");
    wr(`MCC_REG_CHAN_EN, 16'h0001);
    wr(`MCC_REG_CONV_CFG, 16'h000a);
    chk("loopback_en", 16'h0001, {14'h0000, loopback_en});
    chk("meas_restart_a", 16'h0001, {14'h0000, meas_restart});
    chk("src_sel_b_kept", 16'h0005, {12'h000, src_sel_b});
    wr(`MCC_REG_CHAN_EN, 16'h0003);
    wr(`MCC_REG_CONV_CFG, 16'h00b3);
    rd_exp(`MCC_REG_CONV_CFG, 16'h00ba, "cfg_reserved_src");
    rd_exp(`MCC_REG_STATUS, 16'h0010, "status_scale");
    wr(`MCC_REG_CHAN_EN, 16'h0002);
    rd_exp(`MCC_REG_CONV_CFG, 16'h00b5, "cfg_channel_b");
    @(posedge clk);
    sys_state_change <= 2'b01;
    @(posedge clk);
    sys_state_change <= 2'b00;
    step(1);
    chk("src_after_state", 16'h0005, {8'h00, src_sel_a, src_sel_b});
    step(2);
    complete_run();
  end
endmodule
